/* bcr_chk_sva.sv */
`timescale 1ns/100ps
// watches the command link and the refresh counter of the memory end
module bcr_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       cs_n,
    input wire logic [9:0] ca_r,
    input wire logic [9:0] ca_f,
    input wire logic       cnt_clear,
    input wire logic [2:0] ref_bank,
    input wire logic       cmd_error
);
    import bcr_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    // command decode on the link
    wire        rd = !cs_n && ca_r[2:0] == CA_RD;
    wire        wr = !cs_n && ca_r[2:0] == CA_WR;
    wire        rf = !cs_n && ca_r[2:0] == CA_REF;
    wire        cl = !cs_n && ca_r[3:0] == CA_CLOSE;
    logic [7:0] wr_age_reg, rd_age_reg;
    logic [2:0] wr_bank_reg, rd_bank_reg;
    // cycles since the latest write and read, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_age_reg <= 8'hff;
            rd_age_reg <= 8'hff;
        end else begin
            wr_age_reg <= wr ? 8'h00 : wr_age_reg + 8'(wr_age_reg != 8'hff);
            rd_age_reg <= rd ? 8'h00 : rd_age_reg + 8'(rd_age_reg != 8'hff);
        end
    end
    // bank of the latest write and read
    always_ff @(posedge pclk) begin
        if (wr) wr_bank_reg <= ca_r[9:7];
        if (rd) rd_bank_reg <= ca_r[9:7];
    end
    ////////////////////////////////////////////////////////////////////////////
    // spacing, encodings and counter behaviour
    cs_pulse_a: assert property (!cs_n |=> cs_n)
        else $error("commands on adjacent cycles");
    wr_close_a: assert property (cl && (ca_r[4] || ca_r[9:7] == wr_bank_reg) |->
        wr_age_reg >= C_WR2CL - 8'h01)
        else $error("close too soon after write");
    rd_close_a: assert property (cl && (ca_r[4] || ca_r[9:7] == rd_bank_reg) |->
        rd_age_reg >= C_RD2CL - 8'h01)
        else $error("close too soon after read");
    wr_rd_a: assert property (rd |-> wr_age_reg >= C_WRAC2RD - 8'h01)
        else $error("read too soon after write");
    rd_wr_a: assert property (wr |-> rd_age_reg >= C_RDAC2WR - 8'h01)
        else $error("write too soon after read");
    ref_step_a: assert property (rf && !ca_r[3] && !cnt_clear |=> ref_bank == $past(ref_bank) + 3'h1)
        else $error("refresh counter did not advance");
    ref_all_a: assert property (rf && ca_r[3] |=> ref_bank == 3'h0)
        else $error("all bank refresh kept counter");
    cnt_clr_a: assert property (cnt_clear |=> ref_bank == 3'h0)
        else $error("counter not cleared");
    legal_cmd_a: assert property (!cmd_error)
        else $error("memory flagged an illegal command");
    // main scenarios
    cover property (wr && ca_f[0]);
    cover property (rd && ca_f[0]);
    cover property (rf && !ca_r[3]);
    cover property (cl && ca_r[4]);
endmodule

/* bcr_ctrl.sv */
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
// Contract
// - wait write-to-close count before closing bank
// - device refuses close during write recovery; bcr_mem flags cmd_error but still closes the bank
// - array write per complete group of four
// - flag low leaves bank open after burst
// - auto close flag is falling-half bit zero
// - read auto close starts at later count
// - write auto close starts after recovery
// - reopen needs close and row cycle times
// - read to close waits computed count
// - burst cut to close: read 1, write longer
// - reopen after auto close adds single close
// - no access after read auto close, spacing
// - same direction half burst, write-read spacing
// - close to close needs one clock
// - close period from latest close of bank
// - never cut auto close bursts
// - refresh encoding, bit three picks all
// - single bank refresh only eight banks
// - counter refreshes banks zero to seven round
// - counter clears on reset and exit
// - controller mirrors counter, target bank idle
// - single refresh waits three delays
// - only refreshed bank busy, ends idle
// - all refresh needs idle, clears counter
module bcr_ctrl #(
    parameter int NB = bcr_pkg::NBANK
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    bcr_link_if.ctrl              link
);
    import bcr_pkg::*;

    typedef enum logic {ST_IDLE, ST_WAIT} bcr_st_type;

    typedef struct packed {
        bcr_st_type          st;
        logic [3:0]          op;
        logic [2:0]          bank;
        logic                ac;
        logic                rej;
        logic [NB-1:0]       open;
        logic [NB-1:0][7:0]  close_w;  // until close allowed
        logic [NB-1:0][7:0]  act_w;    // until activate/refresh allowed
        logic [7:0]          rd_w;
        logic [7:0]          wr_w;
        logic [7:0]          refa_w;
        logic [7:0]          refo_w;
        logic                gap;
        logic [2:0]          rcnt;
        logic [2:0]          last_bk;
        logic                last_wr;
        logic                last_ac;
        logic                cs_n;
        logic [9:0]          ca_r;
        logic [9:0]          ca_f;
        logic [31:0]         rdata;
    } bcr_cst_type;

    bcr_cst_type r_reg;
    bcr_cst_type r_next;
    logic        ok;
    logic        all_close_ok;
    logic        all_act_ok;
    logic [2:0]  b;
    logic        wr_cmd;
    logic        rd_acc;

    ////////////////////////////////////////////////////////////////////////////
    // apb strobes
    assign wr_cmd  = psel && penable && pwrite && paddr == A_CMD;
    assign rd_acc  = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && paddr != A_CMD && paddr != A_STAT;
    assign prdata  = r_reg.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.cs_n = 1'b1;
        r_next.ca_r = '0;
        r_next.ca_f = '0;
        r_next.gap  = 1'b0;
        b = r_reg.bank;
        ok = 1'b0;
        all_close_ok = 1'b1;
        all_act_ok = 1'b1;
        // count down every spacing timer
        for (int i = 0; i < NB; i++) begin
            r_next.close_w[i] = dn8(r_reg.close_w[i]);
            r_next.act_w[i]   = dn8(r_reg.act_w[i]);
            if (r_reg.close_w[i] != 8'h00) begin
                all_close_ok = 1'b0;
            end
            if (r_reg.act_w[i] != 8'h00) begin
                all_act_ok = 1'b0;
            end
        end
        r_next.rd_w   = dn8(r_reg.rd_w);
        r_next.wr_w   = dn8(r_reg.wr_w);
        r_next.refa_w = dn8(r_reg.refa_w);
        r_next.refo_w = dn8(r_reg.refo_w);
        // legality of the held command
        unique case (bcr_op_type'(r_reg.op))
            OP_NOP:       ok = 1'b1;
            OP_ACT:       ok = !r_reg.open[b] && r_reg.act_w[b] == 8'h00 && r_reg.refa_w == 8'h00;
            OP_RD:        ok = r_reg.open[b] && r_reg.rd_w == 8'h00;
            OP_WR:        ok = r_reg.open[b] && r_reg.wr_w == 8'h00;
            OP_CLOSE:     ok = r_reg.close_w[b] == 8'h00 && !r_reg.gap;
            OP_CLOSE_ALL: ok = all_close_ok && !r_reg.gap;
            OP_CUT:       ok = !r_reg.last_ac;
            OP_REF_ONE:   ok = !r_reg.open[r_reg.rcnt] && r_reg.act_w[r_reg.rcnt] == 8'h00
                               && r_reg.refa_w == 8'h00 && r_reg.refo_w == 8'h00;
            OP_REF_ALL:   ok = r_reg.open == '0 && all_act_ok
                               && r_reg.refa_w == 8'h00 && r_reg.refo_w == 8'h00;
            default:      ok = 1'b1;
        endcase
        // issue: drive link one cycle, book the spacing it creates
        if (r_reg.st == ST_WAIT && ok) begin
            r_next.st = ST_IDLE;
            r_next.ca_r[CA_BANK_LSB +: 3] = b;
            unique case (bcr_op_type'(r_reg.op))
                OP_ACT: begin
                    r_next.cs_n = 1'b0;
                    r_next.ca_r[1:0] = CA_ACT;
                    r_next.open[b] = 1'b1;
                    r_next.act_w[b] = mx8(r_reg.act_w[b], C_ROWCYC);
                end
                OP_RD, OP_WR: begin
                    r_next.cs_n = 1'b0;
                    r_next.ca_f[CA_AC_BIT] = r_reg.ac;
                    r_next.last_bk = b;
                    r_next.last_ac = r_reg.ac;
                    r_next.last_wr = (bcr_op_type'(r_reg.op) == OP_WR);
                    if (bcr_op_type'(r_reg.op) == OP_RD) begin
                        r_next.ca_r[2:0] = CA_RD;
                        r_next.close_w[b] = mx8(r_reg.close_w[b], C_RD2CL);
                        r_next.rd_w = mx8(r_reg.rd_w, C_SAMEDIR);
                        r_next.wr_w = mx8(r_reg.wr_w, C_RDAC2WR);
                        if (r_reg.ac) begin
                            r_next.act_w[b] = mx8(r_reg.act_w[b], 8'(C_RD2CL + C_CLOSE1));
                        end
                    end else begin
                        r_next.ca_r[2:0] = CA_WR;
                        r_next.close_w[b] = mx8(r_reg.close_w[b], C_WR2CL);
                        r_next.wr_w = mx8(r_reg.wr_w, C_SAMEDIR);
                        r_next.rd_w = mx8(r_reg.rd_w, C_WRAC2RD);
                        if (r_reg.ac) begin
                            r_next.act_w[b] = mx8(r_reg.act_w[b], 8'(C_WR2CL + C_CLOSE1));
                        end
                    end
                    if (r_reg.ac) begin
                        r_next.open[b] = 1'b0;
                    end
                end
                OP_CLOSE, OP_CLOSE_ALL: begin
                    r_next.cs_n = 1'b0;
                    r_next.ca_r[3:0] = CA_CLOSE;
                    r_next.ca_r[CA_ALL_BIT] = (bcr_op_type'(r_reg.op) == OP_CLOSE_ALL);
                    r_next.gap = 1'b1;
                    for (int i = 0; i < NB; i++) begin
                        if (bcr_op_type'(r_reg.op) == OP_CLOSE_ALL || b == 3'(i)) begin
                            r_next.open[i] = 1'b0;
                            r_next.act_w[i] = mx8(r_reg.act_w[i], C_CLOSE);
                        end
                    end
                end
                OP_CUT: begin
                    r_next.cs_n = 1'b0;
                    r_next.ca_r[3:0] = CA_CUT;
                    r_next.close_w[r_reg.last_bk] = r_reg.last_wr ? C_CUTW2CL : C_CUTR2CL;
                end
                OP_REF_ONE: begin
                    r_next.cs_n = 1'b0;
                    r_next.ca_r[2:0] = CA_REF;
                    r_next.ca_r[CA_BANK_LSB +: 3] = 3'h0;
                    r_next.act_w[r_reg.rcnt] = mx8(r_reg.act_w[r_reg.rcnt], C_REFONE);
                    r_next.refo_w = C_REFONE;
                    r_next.rcnt = r_reg.rcnt + 3'h1;
                end
                OP_REF_ALL: begin
                    r_next.cs_n = 1'b0;
                    r_next.ca_r[2:0] = CA_REF;
                    r_next.ca_r[CA_REFALL_BIT] = 1'b1;
                    r_next.ca_r[CA_BANK_LSB +: 3] = 3'h0;
                    r_next.refa_w = C_REFALL;
                    r_next.rcnt = 3'h0;
                    for (int i = 0; i < NB; i++) begin
                        r_next.act_w[i] = mx8(r_reg.act_w[i], C_REFALL);
                    end
                end
                default: begin
                    r_next.cs_n = 1'b1;
                end
            endcase
        end
        // register writes: a new order only while idle
        if (wr_cmd) begin
            if (r_reg.st == ST_IDLE) begin
                r_next.st   = ST_WAIT;
                r_next.op   = pwdata[F_OP_LSB +: 4];
                r_next.bank = pwdata[F_BANK_LSB +: 3];
                r_next.ac   = pwdata[F_AC];
                r_next.rej  = 1'b0;
            end else begin
                r_next.rej = 1'b1;
            end
            if (pwdata[F_CLR]) begin
                r_next.rcnt = 3'h0;
            end
        end
        // read data captured in the setup cycle
        if (rd_acc) begin
            r_next.rdata = '0;
            if (paddr == A_STAT) begin
                r_next.rdata[S_PEND] = (r_reg.st == ST_WAIT);
                r_next.rdata[S_RCNT_LSB +: 3] = r_reg.rcnt;
                r_next.rdata[S_REJ] = r_reg.rej;
                r_next.rdata[S_OPEN_LSB +: NB] = r_reg.open;
            end else if (paddr == A_CMD) begin
                r_next.rdata[F_OP_LSB +: 4] = r_reg.op;
                r_next.rdata[F_BANK_LSB +: 3] = r_reg.bank;
                r_next.rdata[F_AC] = r_reg.ac;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.cs_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.cs_n = r_reg.cs_n;
    assign link.ca_r = r_reg.ca_r;
    assign link.ca_f = r_reg.ca_f;

endmodule

/* bcr_link_if.sv */
`timescale 1ns/100ps
// command/address link between controller and memory
interface bcr_link_if;
    logic       cs_n;
    logic [9:0] ca_r;   // rising half
    logic [9:0] ca_f;   // falling half

    modport ctrl (output cs_n, output ca_r, output ca_f);
    modport mem  (input cs_n, input ca_r, input ca_f);
endinterface

/* bcr_mem.sv */
`timescale 1ns/100ps
// memory end: bank state, recovery, auto close and refresh counter
module bcr_mem #(
    parameter int NB = bcr_pkg::NBANK
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    bcr_link_if.mem               link,
    input  wire logic             cnt_clear,
    output logic [NB-1:0]         bank_open,
    output logic [2:0]            ref_bank,
    output logic                  cmd_error,
    output logic                  array_write
);
    import bcr_pkg::*;

    typedef struct packed {
        logic [NB-1:0]       open;
        logic [NB-1:0][7:0]  wrec;   // write recovery left
        logic [NB-1:0][7:0]  acc;    // auto close countdown
        logic [NB-1:0][7:0]  busy;   // close or refresh period left
        logic [2:0]          rcnt;
        logic [2:0]          last_bk;
        logic                last_wr;
        logic [7:0]          wq;     // write data cycles left
        logic                err;
        logic                arr;
    } bcr_mst_type;

    bcr_mst_type r_reg;
    bcr_mst_type r_next;
    logic [2:0]  bk;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.err = 1'b0;
        r_next.arr = 1'b0;
        bk = link.ca_r[CA_BANK_LSB +: 3];
        // timers; auto close starts the close period when it expires
        for (int i = 0; i < NB; i++) begin
            r_next.wrec[i] = dn8(r_reg.wrec[i]);
            r_next.busy[i] = dn8(r_reg.busy[i]);
            r_next.acc[i]  = dn8(r_reg.acc[i]);
            if (r_reg.acc[i] == 8'h01) begin
                r_next.open[i] = 1'b0;
                r_next.busy[i] = C_CLOSE;
            end
        end
        // array write after each complete group of four words
        if (r_reg.wq != 8'h00) begin
            r_next.wq = r_reg.wq - 8'h01;
            if (r_reg.wq <= C_HALF && r_reg.wq[0]) begin
                r_next.arr = 1'b1;
            end
        end
        // command decode
        if (!link.cs_n) begin
            if (link.ca_r[1:0] == CA_ACT) begin
                if (r_reg.open[bk] || r_reg.busy[bk] != 8'h00 || r_reg.acc[bk] != 8'h00) begin
                    r_next.err = 1'b1;
                end else begin
                    r_next.open[bk] = 1'b1;
                end
            end else if (link.ca_r[2:0] == CA_RD || link.ca_r[2:0] == CA_WR) begin
                if (!r_reg.open[bk] || r_reg.acc[bk] != 8'h00) begin
                    r_next.err = 1'b1;
                end else begin
                    r_next.last_bk = bk;
                    r_next.last_wr = (link.ca_r[2:0] == CA_WR);
                    if (link.ca_r[2:0] == CA_WR) begin
                        r_next.wrec[bk] = C_WR2CL;
                        r_next.wq = C_WDATA;
                    end
                    // low flag leaves the bank open
                    if (link.ca_f[CA_AC_BIT]) begin
                        r_next.acc[bk] = (link.ca_r[2:0] == CA_WR) ? C_WR2CL : C_RD2CL;
                    end
                end
            end else if (link.ca_r[3:0] == CA_CLOSE) begin
                for (int i = 0; i < NB; i++) begin
                    if (link.ca_r[CA_ALL_BIT] || bk == 3'(i)) begin
                        if (r_reg.wrec[i] != 8'h00) begin
                            r_next.err = 1'b1;
                        end
                        r_next.open[i] = 1'b0;
                        r_next.busy[i] = mx8(r_reg.busy[i], C_CLOSE);
                    end
                end
            end else if (link.ca_r[3:0] == CA_CUT) begin
                if (r_reg.last_wr) begin
                    r_next.wrec[r_reg.last_bk] = C_CUTW2CL;
                    if (r_reg.wq > C_WLAT) begin
                        r_next.wq = C_WLAT;
                    end
                end
            end else if (link.ca_r[2:0] == CA_REF) begin
                if (link.ca_r[CA_REFALL_BIT]) begin
                    if (|r_reg.open) begin
                        r_next.err = 1'b1;
                    end else begin
                        r_next.rcnt = 3'h0;
                        for (int i = 0; i < NB; i++) begin
                            r_next.busy[i] = mx8(r_reg.busy[i], C_REFALL);
                        end
                    end
                end else if (NB != 8) begin
                    r_next.err = 1'b1;
                end else if (r_reg.open[r_reg.rcnt] || r_reg.busy[r_reg.rcnt] != 8'h00) begin
                    r_next.err = 1'b1;
                end else begin
                    // only the counted bank goes busy; it ends idle
                    r_next.busy[r_reg.rcnt] = C_REFONE;
                    r_next.rcnt = r_reg.rcnt + 3'h1;
                end
            end
        end
        if (cnt_clear) begin
            r_next.rcnt = 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bank_open   = r_reg.open;
    assign ref_bank    = r_reg.rcnt;
    assign cmd_error   = r_reg.err;
    assign array_write = r_reg.arr;

endmodule

/* bcr_pkg.sv */
package bcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // geometry and latencies
    localparam int NBANK      = 8;
    localparam int CK_NS      = 5;
    localparam int BURST_LEN  = 8;
    localparam int WRITE_LAT  = 1;
    localparam int READ_LAT   = 3;

    // analog times in ns
    localparam int T_WREC_NS   = 15;   // write recovery
    localparam int T_RD2CL_NS  = 8;    // read to close
    localparam int T_CLOSE_NS  = 18;   // close period
    localparam int T_CLOSE1_NS = 18;   // single bank close period
    localparam int T_ROWCYC_NS = 60;   // row cycle
    localparam int T_WR2RD_NS  = 8;    // write to read
    localparam int T_SKEW_NS   = 6;    // max strobe skew
    localparam int T_REFALL_NS = 130;  // all bank refresh cycle
    localparam int T_REFONE_NS = 60;   // single bank refresh cycle

    // whole cycles, rounded up
    function automatic int roundup(input int ns);
        return (ns + CK_NS - 1) / CK_NS;
    endfunction

    localparam int WREC_C  = roundup(T_WREC_NS);
    localparam int RD2CL_C = roundup(T_RD2CL_NS);
    localparam int HALF    = BURST_LEN / 2;

    ////////////////////////////////////////////////////////////////////////////
    // command to command counts in cycles
    localparam logic [7:0] C_WR2CL   = 8'(WRITE_LAT + HALF + 1 + WREC_C);
    localparam logic [7:0] C_RD2CL   = 8'(HALF + ((RD2CL_C > 2) ? RD2CL_C : 2) - 2);
    localparam logic [7:0] C_CUTR2CL = 8'(1);
    localparam logic [7:0] C_CUTW2CL = 8'(WRITE_LAT + WREC_C + 1);
    localparam logic [7:0] C_CLOSE   = 8'(roundup(T_CLOSE_NS));
    localparam logic [7:0] C_CLOSE1  = 8'(roundup(T_CLOSE1_NS));
    localparam logic [7:0] C_ROWCYC  = 8'(roundup(T_ROWCYC_NS));
    localparam logic [7:0] C_RDAC2WR = 8'(READ_LAT + HALF + roundup(T_SKEW_NS) - WRITE_LAT + 1);
    localparam logic [7:0] C_WRAC2RD = 8'(WRITE_LAT + HALF + roundup(T_WR2RD_NS) + 1);
    localparam logic [7:0] C_SAMEDIR = 8'(HALF);
    localparam logic [7:0] C_REFALL  = 8'(roundup(T_REFALL_NS));
    localparam logic [7:0] C_REFONE  = 8'(roundup(T_REFONE_NS));
    localparam logic [7:0] C_WDATA   = 8'(WRITE_LAT + HALF);
    localparam logic [7:0] C_HALF    = 8'(HALF);
    localparam logic [7:0] C_WLAT    = 8'(WRITE_LAT);

    ////////////////////////////////////////////////////////////////////////////
    // command/address encodings
    localparam logic [1:0] CA_ACT   = 2'h2;  // ca1..0
    localparam logic [2:0] CA_RD    = 3'h5;  // ca2..0
    localparam logic [2:0] CA_WR    = 3'h1;
    localparam logic [2:0] CA_REF   = 3'h4;
    localparam logic [3:0] CA_CLOSE = 4'hb;  // ca3..0
    localparam logic [3:0] CA_CUT   = 4'h3;
    localparam int CA_REFALL_BIT = 3;
    localparam int CA_ALL_BIT    = 4;
    localparam int CA_BANK_LSB   = 7;
    localparam int CA_AC_BIT     = 0;        // falling half

    ////////////////////////////////////////////////////////////////////////////
    // controller registers
    localparam logic [7:0] A_CMD  = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam int F_OP_LSB   = 0;
    localparam int F_BANK_LSB = 4;
    localparam int F_AC       = 8;
    localparam int F_CLR      = 9;
    localparam int S_PEND     = 0;
    localparam int S_RCNT_LSB = 1;
    localparam int S_REJ      = 4;
    localparam int S_OPEN_LSB = 8;

    typedef enum logic [3:0] {
        OP_NOP, OP_ACT, OP_RD, OP_WR, OP_CLOSE, OP_CLOSE_ALL, OP_CUT, OP_REF_ONE, OP_REF_ALL
    } bcr_op_type;

    function automatic logic [7:0] dn8(input logic [7:0] v);
        return (v == 8'h00) ? v : v - 8'h01;
    endfunction

    function automatic logic [7:0] mx8(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction

endpackage

/* tb.sv */
`timescale 1ns/100ps
// random command traffic through the register port against a bank model
module tb;
    import bcr_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, cnt_clear, pready, pslverr, cmd_error, array_write, e, ac;
    logic [7:0]  paddr, bank_open, open_m;
    logic [31:0] pwdata, prdata, r;
    logic [2:0]  ref_bank, rcnt_m;
    int          fails = 0, compares = 0, cyc = 0, wcnt = 0, exp_w = 0, b, op, cut_ok = 0;
    bcr_link_if bcr_link_if_inst ();
    bcr_ctrl bcr_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(bcr_link_if_inst.ctrl));
    bcr_mem bcr_mem_inst (.pclk(pclk), .presetn(presetn), .link(bcr_link_if_inst.mem), .cnt_clear(cnt_clear),
        .bank_open(bank_open), .ref_bank(ref_bank), .cmd_error(cmd_error), .array_write(array_write));
    bcr_chk bcr_chk_inst (.pclk(pclk), .presetn(presetn), .cs_n(bcr_link_if_inst.cs_n), .ca_r(bcr_link_if_inst.ca_r),
        .ca_f(bcr_link_if_inst.ca_f), .cnt_clear(cnt_clear), .ref_bank(ref_bank), .cmd_error(cmd_error));
    always #2.5 pclk = ~pclk;
    // array write pulses and the run limit
    always @(posedge pclk) begin
        cyc++;
        if (array_write === 1'b1) wcnt++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task summarize();
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] s);
        compares++;
        if (s !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task idle();
        r = 32'h1;
        while (r[S_PEND] !== 1'b0) apb(1'b0, A_STAT, 32'h0);
    endtask
    function automatic logic [7:0] nxt_open(input logic [7:0] m, input int o, input int k, input logic f);
        if (o == 1) m[k] = 1'b1;
        if (o == 4 || ((o == 2 || o == 3) && f)) m[k] = 1'b0;
        return (o == 5) ? 8'h00 : m;
    endfunction
    // issue one command, wait until it has left, compare with the model
    task cmd(input int o, input int k, input logic f);
        apb(1'b1, A_CMD, 32'(o) | (32'(k) << F_BANK_LSB) | (32'(f) << F_AC));
        idle();
        open_m = nxt_open(open_m, o, k, f);
        if (o == 7) rcnt_m++;
        if (o == 8) rcnt_m = 3'h0;
        if (o == 3) exp_w += BURST_LEN / 4;
        chk("open mask", open_m, r[15:8]);
        chk("counter copy", rcnt_m, r[3:1]);
        chk("ref_bank", rcnt_m, ref_bank);
        chk("rejected", 0, r[S_REJ]);
        chk("slverr mapped", 0, e);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, cnt_clear, paddr, pwdata} = '0;
        open_m = 8'h00;
        rcnt_m = 3'h0;
        void'($urandom(32'hd218f72b));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("ref_bank reset", 0, ref_bank);
        apb(1'b0, 8'h08, 32'h0);
        chk("slverr", 1, e);
        chk("unmapped", 0, r);
        // random traffic: open closed banks, else read, write, close, close all or cut
        repeat (60) begin
            b = $urandom_range(7, 0);
            op = open_m[b] ? $urandom_range(6, 2) : 1;
            if (op == 6 && cut_ok == 0) op = 2;
            ac = 1'($urandom_range(1, 0));
            cmd(op, b, ac);
            cut_ok = ((op == 2 || op == 3) && !ac);
        end
        repeat (40) @(posedge pclk);
        chk("bank_open", open_m, bank_open);
        chk("array writes", exp_w, wcnt);
        // refresh rotation past the wrap, with another bank open meanwhile
        cmd(5, 0, 1'b0);
        for (int i = 0; i < 9; i++) cmd(7, 0, 1'b0);
        cmd(1, 5, 1'b0);
        cmd(7, 0, 1'b0);
        cmd(2, 5, 1'b0);
        cmd(5, 0, 1'b0);
        cmd(8, 0, 1'b0);
        cmd(7, 0, 1'b0);
        cnt_clear <= 1'b1;
        @(posedge pclk);
        cnt_clear <= 1'b0;
        @(posedge pclk);
        chk("cleared ref_bank", 0, ref_bank);
        apb(1'b1, A_CMD, 32'h1 << F_CLR);
        rcnt_m = 3'h0;
        idle();
        chk("cleared copy", 0, r[3:1]);
        // second order while the first waits out the refresh cycle
        cmd(7, 0, 1'b0);
        apb(1'b1, A_CMD, 32'h7);
        apb(1'b1, A_CMD, 32'h7);
        idle();
        rcnt_m++;
        chk("rejected order", 1, r[S_REJ]);
        cmd(7, 0, 1'b0);
        // order register reads back op, bank and flag
        apb(1'b0, A_CMD, 32'h0);
        chk("order readback", 32'h7, r);
        summarize();
    end
endmodule
